/* File: i2c_dac_defines.vh */
`ifndef I2C_DAC_DEFINES_VH
`define I2C_DAC_DEFINES_VH

// ----------------------------------------------------------------
// slave address
// ----------------------------------------------------------------
`define ADDR_FIXED_SIX     6'h06
`define ADDR_FIXED_FIVE    5'h03
`define ADDR_BYTE_BITS     4'h8

// ----------------------------------------------------------------
// input word field positions
// ----------------------------------------------------------------
`define WORD_MODE_HI_BIT   13
`define WORD_MODE_LO_BIT   12
`define WORD_CODE_MSB      11
`define WORD_CODE_LSB      0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DAC_CODE_RST       12'h000
`define PWR_MODE_RST       2'h0

// ----------------------------------------------------------------
// power-mode encodings
// ----------------------------------------------------------------
`define MODE_NORMAL        2'h0
`define MODE_PD_1K         2'h1
`define MODE_PD_100K       2'h2
`define MODE_PD_TRISTATE   2'h3

`endif

/* File: pin_sync2.v */
`timescale 1ns/10ps

// two-flop synchroniser, one stage pair per bit
module pin_sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             sys_clk_i,
    input  wire             rstn_i,
    // pins in, synchronised out
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // reset high: the i2c lines idle high and the power-down pin is active low
            always @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta[i]   <= 1'b1;
                    stable[i] <= 1'b1;
                end else begin
                    meta[i]   <= async_i[i];
                    stable[i] <= meta[i];
                end
            end
        end
    endgenerate

    assign sync_o = stable;

endmodule // pin_sync2

/* File: pwr_mode_decode.v */
`timescale 1ns/10ps
`include "i2c_dac_defines.vh"

// registered decode of the programmed power mode plus the hardware override
module pwr_mode_decode #(
    parameter EIGHT_LEAD = 1
) (
    // clock and reset
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    // programmed mode and override pin (already synchronised)
    input  wire [1:0] pwr_mode_i,
    input  wire       hw_powerdown_n_i,
    // output stage selection
    output reg  [1:0] out_mode_o,
    output reg        out_normal_o,
    output reg        out_pd_1k_o,
    output reg        out_pd_100k_o,
    output reg        out_pd_tristate_o
);

    reg [1:0] next_mode;

    always @* begin
        next_mode = pwr_mode_i;
        // pin only exists on the eight-lead part; it beats the software bits
        if ((EIGHT_LEAD != 0) && !hw_powerdown_n_i) begin
            next_mode = `MODE_PD_TRISTATE;
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_mode_o        <= `MODE_NORMAL;
            out_normal_o      <= 1'b1;
            out_pd_1k_o       <= 1'b0;
            out_pd_100k_o     <= 1'b0;
            out_pd_tristate_o <= 1'b0;
        end else begin
            out_mode_o        <= next_mode;
            out_normal_o      <= (next_mode == `MODE_NORMAL);
            out_pd_1k_o       <= (next_mode == `MODE_PD_1K);
            out_pd_100k_o     <= (next_mode == `MODE_PD_100K);
            out_pd_tristate_o <= (next_mode == `MODE_PD_TRISTATE);
        end
    end

endmodule // pwr_mode_decode

/* File: i2c_dac_control_port.v */
// Contract
// - six-lead part answers address 000110 plus the low select pin.
// - eight-lead part answers address 00011 plus bit1 and low select pins.
// - slave only; the serial clock line is never driven.
// - start is sda falling while scl high; begins an address byte.
// - first byte is seven address bits then direction, high means read.
// - on a match, sda is pulled low during the ninth pulse.
// - on a mismatch, stay idle and never drive sda that transaction.
// - nine pulses per byte; sda changes only while scl is low.
// - master ends with stop, sda rising while scl high.
// - writes carry two data bytes; reads return one or two bytes.
// - each completed byte pair in one write updates the dac register.
// - repeated reads return the current register contents each time.
// - write data shifts into a sixteen-bit word, bit 15 first.
// - two leading bits ignored, then two mode bits, then code.
// - code is left-justified after mode bits, width 8, 10 or 12.
// - mode high is word bit 13, mode low is word bit 12.
// - mode 00 normal, 01 1k to ground, 10 100k, 11 three-state.
// - eight-lead power-down pin low forces three-state regardless of mode bits.
// - power-down leaves the stored dac code unchanged.
// - reset clears the dac register until the first valid write.
// - 8-bit reads one code byte; others read two bytes with mode.
// - sda is open drain: pulled low or released, never driven high.
//
`timescale 1ns/10ps
`include "i2c_dac_defines.vh"

module i2c_dac_control_port #(
    parameter EIGHT_LEAD = 1,
    parameter RESOLUTION = 12
) (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    // i2c pins
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_o,
    // straps and hardware power-down
    input  wire        addr_select_low_pin_i,
    input  wire        addr_select_bit1_pin_i,
    input  wire        hw_powerdown_n_i,
    // dac register
    output reg  [11:0] dac_code_o,
    output reg         pwr_mode_hi_o,
    output reg         pwr_mode_lo_o,
    output reg         dac_update_o,
    // effective output stage
    output wire [1:0]  out_mode_o,
    output wire        out_normal_o,
    output wire        out_pd_1k_o,
    output wire        out_pd_100k_o,
    output wire        out_pd_tristate_o,
    // status
    output reg         addressed_o
);

    // ----------------------------------------------------------------
    // states and constants
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_ADDR    = 3'h1;
    localparam [2:0] ST_ADDR_AK = 3'h2;
    localparam [2:0] ST_WR_DATA = 3'h3;
    localparam [2:0] ST_WR_AK   = 3'h4;
    localparam [2:0] ST_RD_DATA = 3'h5;
    localparam [2:0] ST_RD_AK   = 3'h6;

    // bits of the word that carry code for this resolution
    localparam [11:0] CODE_MASK = 12'hfff << (12 - RESOLUTION);
    localparam        TWO_BYTE  = (RESOLUTION != 8);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [4:0] pins_sync;
    wire       scl_s;
    wire       sda_s;
    wire       a0_s;
    wire       a1_s;
    wire       pd_n_s;

    pin_sync2 #(
        .WIDTH (5)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .async_i   ({hw_powerdown_n_i, addr_select_bit1_pin_i,
                     addr_select_low_pin_i, sda_i, scl_i}),
        .sync_o    (pins_sync)
    );

    assign scl_s  = pins_sync[0];
    assign sda_s  = pins_sync[1];
    assign a0_s   = pins_sync[2];
    assign a1_s   = pins_sync[3];
    assign pd_n_s = pins_sync[4];

    // ----------------------------------------------------------------
    // bus event detection
    // ----------------------------------------------------------------
    reg scl_d;
    reg sda_d;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    wire scl_rise   = scl_s & ~scl_d;
    wire scl_fall   = ~scl_s & scl_d;
    wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

    // ----------------------------------------------------------------
    // address compare
    // ----------------------------------------------------------------
    reg [6:0] own_addr;

    always @* begin
        if (EIGHT_LEAD != 0) begin
            own_addr = {`ADDR_FIXED_FIVE, a1_s, a0_s};
        end else begin
            own_addr = {`ADDR_FIXED_SIX, a0_s};
        end
    end

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    reg [2:0]  state;
    reg [3:0]  bit_cnt;
    reg [7:0]  rx_shift;
    reg [7:0]  upper_byte;
    reg        second_byte;
    reg        read_dir;
    reg [7:0]  tx_shift;
    reg        rd_lower;
    reg        master_ack;
    reg        pull_low;

    // readback image of the dac register
    wire [15:0] rd_word  = {2'h0, pwr_mode_hi_o, pwr_mode_lo_o, dac_code_o};
    wire [7:0]  rd_first = TWO_BYTE ? rd_word[15:8] : dac_code_o[11:4];
    wire [15:0] wr_word  = {upper_byte, rx_shift};

    // sda only ever pulled low, so the data output is a constant zero
    assign sda_o    = 1'b0;
    assign sda_oe_o = pull_low;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state         <= ST_IDLE;
            bit_cnt       <= 4'h0;
            rx_shift      <= 8'h00;
            upper_byte    <= 8'h00;
            second_byte   <= 1'b0;
            read_dir      <= 1'b0;
            tx_shift      <= 8'h00;
            rd_lower      <= 1'b0;
            master_ack    <= 1'b0;
            pull_low      <= 1'b0;
            dac_code_o    <= `DAC_CODE_RST;
            pwr_mode_hi_o <= 1'b0;
            pwr_mode_lo_o <= 1'b0;
            dac_update_o  <= 1'b0;
            addressed_o   <= 1'b0;
        end else begin
            dac_update_o <= 1'b0;
            if (start_seen) begin
                // start (or repeated start) always restarts address reception
                state       <= ST_ADDR;
                bit_cnt     <= 4'h0;
                second_byte <= 1'b0;
                pull_low    <= 1'b0;
                addressed_o <= 1'b0;
            end else if (stop_seen) begin
                state       <= ST_IDLE;
                pull_low    <= 1'b0;
                addressed_o <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        pull_low <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bit_cnt  <= bit_cnt + 4'h1;
                        end else if (scl_fall && (bit_cnt == `ADDR_BYTE_BITS)) begin
                            bit_cnt <= 4'h0;
                            if (rx_shift[7:1] == own_addr) begin
                                read_dir    <= rx_shift[0];
                                pull_low    <= 1'b1;
                                addressed_o <= 1'b1;
                                state       <= ST_ADDR_AK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_AK: begin
                        // leave the ack slot on the falling edge of the ninth pulse
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (read_dir) begin
                                tx_shift <= {rd_first[6:0], 1'b0};
                                pull_low <= ~rd_first[7];
                                rd_lower <= 1'b0;
                                state    <= ST_RD_DATA;
                            end else begin
                                pull_low <= 1'b0;
                                state    <= ST_WR_DATA;
                            end
                        end
                    end
                    ST_WR_DATA: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bit_cnt  <= bit_cnt + 4'h1;
                        end else if (scl_fall && (bit_cnt == `ADDR_BYTE_BITS)) begin
                            bit_cnt  <= 4'h0;
                            pull_low <= 1'b1;
                            state    <= ST_WR_AK;
                        end
                    end
                    ST_WR_AK: begin
                        if (scl_fall) begin
                            pull_low <= 1'b0;
                            state    <= ST_WR_DATA;
                            if (second_byte) begin
                                // bits 15:14 dropped, mode and code taken
                                pwr_mode_hi_o <= wr_word[`WORD_MODE_HI_BIT];
                                pwr_mode_lo_o <= wr_word[`WORD_MODE_LO_BIT];
                                dac_code_o    <= wr_word[`WORD_CODE_MSB:`WORD_CODE_LSB]
                                                 & CODE_MASK;
                                dac_update_o  <= 1'b1;
                                second_byte   <= 1'b0;
                            end else begin
                                upper_byte  <= rx_shift;
                                second_byte <= 1'b1;
                            end
                        end
                    end
                    ST_RD_DATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == `ADDR_BYTE_BITS) begin
                                bit_cnt  <= 4'h0;
                                pull_low <= 1'b0;
                                state    <= ST_RD_AK;
                            end else begin
                                pull_low <= ~tx_shift[7];
                                tx_shift <= {tx_shift[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RD_AK: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_s;
                        end else if (scl_fall) begin
                            if (!master_ack) begin
                                // no-acknowledge: let the master make its stop
                                state       <= ST_IDLE;
                                addressed_o <= 1'b0;
                            end else if (TWO_BYTE && !rd_lower) begin
                                tx_shift <= {rd_word[6:0], 1'b0};
                                pull_low <= ~rd_word[7];
                                rd_lower <= 1'b1;
                                state    <= ST_RD_DATA;
                            end else begin
                                // further acks wrap round to a fresh copy
                                tx_shift <= {rd_first[6:0], 1'b0};
                                pull_low <= ~rd_first[7];
                                rd_lower <= 1'b0;
                                state    <= ST_RD_DATA;
                            end
                        end
                    end
                    default: begin
                        state    <= ST_IDLE;
                        pull_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // output stage selection
    // ----------------------------------------------------------------
    // the code register is left alone here, so a wake-up reuses it
    pwr_mode_decode #(
        .EIGHT_LEAD (EIGHT_LEAD)
    ) u_pwr (
        .sys_clk_i         (sys_clk_i),
        .rstn_i            (rstn_i),
        .pwr_mode_i        ({pwr_mode_hi_o, pwr_mode_lo_o}),
        .hw_powerdown_n_i  (pd_n_s),
        .out_mode_o        (out_mode_o),
        .out_normal_o      (out_normal_o),
        .out_pd_1k_o       (out_pd_1k_o),
        .out_pd_100k_o     (out_pd_100k_o),
        .out_pd_tristate_o (out_pd_tristate_o)
    );

endmodule // i2c_dac_control_port

/* File: i2c_dac_control_port_sva.sv */
`timescale 1ns/10ps

module i2c_dac_control_port_sva #(
    parameter EIGHT_LEAD = 1
) (
    // clock and reset
    input wire        sys_clk_i,
    input wire        rstn_i,
    // bus pins and hardware power-down
    input wire        scl_i,
    input wire        sda_i,
    input wire        sda_o,
    input wire        sda_oe_o,
    input wire        hw_powerdown_n_i,
    // dac register and output stage
    input wire [11:0] dac_code_o,
    input wire        pwr_mode_hi_o,
    input wire        pwr_mode_lo_o,
    input wire        dac_update_o,
    input wire [1:0]  out_mode_o,
    input wire        out_normal_o,
    input wire        out_pd_1k_o,
    input wire        out_pd_100k_o,
    input wire        out_pd_tristate_o,
    input wire        addressed_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");

    property p_one_hot;
        {out_pd_tristate_o, out_pd_100k_o, out_pd_1k_o, out_normal_o} == (4'h1 << out_mode_o);
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("output stage not one-hot");

    // five samples cover the pin synchroniser plus the decode register
    property p_hw_pd;
        (EIGHT_LEAD != 0 && !hw_powerdown_n_i) [*5] |-> out_mode_o == 2'h3;
    endproperty
    a_hw_pd: assert property (p_hw_pd) else $error("pin power-down ignored");

    property p_mode_follow;
        (hw_powerdown_n_i && $stable({pwr_mode_hi_o, pwr_mode_lo_o})) [*5]
            |-> out_mode_o == {pwr_mode_hi_o, pwr_mode_lo_o};
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode not applied");

    property p_hold_code;
        $changed({dac_code_o, pwr_mode_hi_o, pwr_mode_lo_o}) |-> dac_update_o;
    endproperty
    a_hold_code: assert property (p_hold_code) else $error("register moved alone");

    property p_commit;
        dac_update_o |-> !scl_i ##1 !dac_update_o;
    endproperty
    a_commit: assert property (p_commit) else $error("commit misplaced");

    property p_sda_in_low;
        $changed(sda_oe_o) |-> !scl_i;
    endproperty
    a_sda_in_low: assert property (p_sda_in_low) else $error("sda moved in scl high");

    property p_start_idle;
        (scl_i && $fell(sda_i)) |-> ##[1:8] !addressed_o;
    endproperty
    a_start_idle: assert property (p_start_idle) else $error("start not seen");

    property p_stop_idle;
        (scl_i && $rose(sda_i)) |-> ##[1:8] !addressed_o;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
endmodule // i2c_dac_control_port_sva

bind i2c_dac_control_port i2c_dac_control_port_sva #(.EIGHT_LEAD(EIGHT_LEAD)) u_sva (
    .sys_clk_i, .rstn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .hw_powerdown_n_i,
    .dac_code_o, .pwr_mode_hi_o, .pwr_mode_lo_o, .dac_update_o, .out_mode_o,
    .out_normal_o, .out_pd_1k_o, .out_pd_100k_o, .out_pd_tristate_o, .addressed_o);

/* File: i2c_master_model.sv */
`timescale 1ns/10ps

// bus master; scl stands high between frames, a 160 ns bit period
module i2c_master_model (
    // clock
    input  wire sys_clk_i,
    // bus
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_oe_o
);
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    task tick(input integer n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task start_cond;
        tick(8);
        sda_oe_o <= 1'b0;
        tick(8);
        scl_o <= 1'b1;
        tick(16);
        sda_oe_o <= 1'b1;
        tick(16);
        scl_o <= 1'b0;
    endtask

    task stop_cond;
        tick(8);
        sda_oe_o <= 1'b1;
        tick(8);
        scl_o <= 1'b1;
        tick(16);
        sda_oe_o <= 1'b0;
        tick(16);
    endtask

    // data moves only mid-low, sampled at the end of high
    task bit_io(input b, output r);
        tick(8);
        sda_oe_o <= ~b;
        tick(8);
        scl_o <= 1'b1;
        tick(16);
        r = sda_i;
        scl_o <= 1'b0;
    endtask

    task byte_io(input [7:0] d, input m_ack, output [7:0] q, output s_ack);
        integer i;
        reg     a;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(d[i], a);
            q[i] = a;
        end
        bit_io(~m_ack, a);
        s_ack = ~a;
    endtask
endmodule // i2c_master_model

/* File: i2c_dac_control_port_tb_top.sv */
`timescale 1ns/10ps

module i2c_dac_control_port_tb_top;
    localparam RES = 12;
    reg         sys_clk_i = 1'b0;
    reg         rstn_i    = 1'b0;
    reg         a0        = 1'b0;
    reg         a1        = 1'b0;
    reg         hw_pd_n   = 1'b1;
    wire        scl;
    wire        m_oe;
    wire        sda_o;
    wire        sda_oe_o;
    wire [11:0] dac_code_o;
    wire        pwr_mode_hi_o;
    wire        pwr_mode_lo_o;
    wire        dac_update_o;
    wire [1:0]  out_mode_o;
    wire        out_normal_o;
    wire        out_pd_1k_o;
    wire        out_pd_100k_o;
    wire        out_pd_tristate_o;
    wire        addressed_o;
    // pull-up wins unless someone pulls low
    wire        sda = ~(m_oe | (sda_oe_o & ~sda_o));
    integer     fails = 0, n_tests = 0, n_upd = 0, i, k;
    integer     exp_code = 0, exp_mode = 0, exp_upd = 0;
    reg [31:0]  seed = 32'h0c1208dd;
    reg [7:0]   q;
    reg         ack;

    always #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (dac_update_o === 1'b1) n_upd = n_upd + 1;

    i2c_dac_control_port #(.EIGHT_LEAD(1), .RESOLUTION(RES)) u_dut (
        .sys_clk_i, .rstn_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
        .addr_select_low_pin_i(a0), .addr_select_bit1_pin_i(a1), .hw_powerdown_n_i(hw_pd_n),
        .dac_code_o, .pwr_mode_hi_o, .pwr_mode_lo_o, .dac_update_o, .out_mode_o,
        .out_normal_o, .out_pd_1k_o, .out_pd_100k_o, .out_pd_tristate_o, .addressed_o);

    i2c_master_model u_mst (.sys_clk_i, .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

    // ----
    // helpers
    // ----
    function [6:0] my_addr(input flip);
        my_addr = {5'h03, a1, a0 ^ flip};
    endfunction

    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task wait_clk(input integer n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task chk_reg;
        n_tests = n_tests + 1;
        if (dac_code_o !== exp_code[11:0] || n_upd != exp_upd
            || {pwr_mode_hi_o, pwr_mode_lo_o} !== exp_mode[1:0]) begin
            fails = fails + 1;
            $display("Error %0t: dac register mismatch", $time);
        end
    endtask

    task chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_out(input [1:0] m);
        chk_val({2'h0, out_mode_o, out_pd_tristate_o, out_pd_100k_o, out_pd_1k_o,
                 out_normal_o}, {2'h0, m, 4'h1 << m});
    endtask

    task send_addr(input [6:0] a, input rw, input hit);
        u_mst.start_cond;
        u_mst.byte_io({a, rw}, 1'b0, q, ack);
        chk_val({7'h00, ack}, {7'h00, hit});
        chk_val({7'h00, addressed_o}, {7'h00, hit});
    endtask

    task wr_word(input [15:0] w, input hit);
        u_mst.byte_io(w[15:8], 1'b0, q, ack);
        chk_val({7'h00, ack}, {7'h00, hit});
        u_mst.byte_io(w[7:0], 1'b0, q, ack);
        chk_val({7'h00, ack}, {7'h00, hit});
        if (hit) begin
            exp_code = w[11:0] & (12'hfff << (12 - RES));
            exp_mode = w[13:12];
            exp_upd  = exp_upd + 1;
        end
        wait_clk(8);
        chk_reg;
    endtask

    task rd_xact(input integer n);
        send_addr(my_addr(1'b0), 1'b1, 1'b1);
        for (k = 0; k < n; k = k + 1) begin
            u_mst.byte_io(8'hff, k < n - 1, q, ack);
            chk_val(q, (k % 2) ? exp_code[7:0] : {2'h0, exp_mode[1:0], exp_code[11:8]});
        end
        u_mst.stop_cond;
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----
    // sequence
    // ----
    initial begin
        wait_clk(4);
        rstn_i <= 1'b1;
        wait_clk(4);
        chk_reg;
        chk_out(2'h0);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr_next(seed);
            a0 <= i[0];
            a1 <= i[1];
            wait_clk(8);
            send_addr(my_addr(1'b0), 1'b0, 1'b1);
            wr_word(seed[15:0], 1'b1);
            u_mst.stop_cond;
            send_addr(my_addr(1'b1), 1'b0, 1'b0);
            wr_word(seed[31:16], 1'b0);
            u_mst.stop_cond;
        end
        $display("test address done");
        send_addr(my_addr(1'b0), 1'b0, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr_next(seed);
            wr_word({seed[15:14], i[1:0], seed[11:0]}, 1'b1);
            wait_clk(8);
            chk_out(i[1:0]);
        end
        u_mst.byte_io(seed[23:16], 1'b0, q, ack);
        // repeated start while still addressed: the odd byte must be dropped
        rd_xact(3);
        wait_clk(8);
        chk_reg;
        $display("test modes done");
        rd_xact(2);
        $display("test readback done");
        send_addr(my_addr(1'b0), 1'b0, 1'b1);
        wr_word({4'hc, seed[27:16]}, 1'b1);
        u_mst.stop_cond;
        hw_pd_n <= 1'b0;
        wait_clk(8);
        chk_out(2'h3);
        chk_reg;
        hw_pd_n <= 1'b1;
        wait_clk(8);
        chk_out(2'h0);
        $display("test power-down done");
        close_out;
    end

    initial begin
        #200000;
        fails = fails + 1;
        $display("Error %0t: watchdog expired", $time);
        close_out;
    end
endmodule // i2c_dac_control_port_tb_top
